//--- src/rtev_core.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: each vector is a 4-byte entry at vector times four, low 16 bits, up to 91.
// RULE2: reset 0, manual 1, trace 5, nmi 7, traps 8-11, pins 16-23, internal 24-91.
// RULE3: vectors 2-4, 6 and 12-15 are never generated.
// RULE4: a reset request beats every other pending exception.
// RULE5: while the reset pin is low all processing stops in reset state.
// RULE6: reset handling starts only on the reset pin rising. A watchdog request also starts it, with no pin edge.
// RULE7: interrupt control mode is forced to 0 after any reset.
// RULE8: manual variant samples nmi pin during reset: high power-on, low manual.
// RULE9: watchdog reset is power-on without manual variant, else select bit decides.
// RULE10: cpu state always reset; manual reset spares bus controller and ports.
// RULE11: after manual reset, module pins fall back to general port control.
// RULE12: outside controller holds reset low 20 ms at power-up, 20 states otherwise.
// RULE13: reset entry clears trace bit and sets the interrupt mask bits.
// RULE14: reset vector is read into the program counter and execution starts.
// RULE15: no interrupt, nmi included, before the first instruction completes.
// RULE16: module stop control loads 3FFF on reset release.
// RULE17: trace works only in mode 2, never in mode 0.
// RULE18: trace bit set raises a trace exception after each instruction.
// RULE19: only clearing the trace bit ends trace; masks do not gate it.
// RULE20: trace entry sets mask bit, clears trace bit, keeps user bit and level.
// RULE21: interrupts stay acceptable inside the trace handler; pin requests stay blocked there by the mask bit that trace entry sets.
// RULE22: no trace after return from exception; restored trace bit resumes it.
// RULE23: pending order is reset, trace, interrupt, trap.
// RULE24: non-reset exceptions push pc, condition and extended control before mask update and vectoring; push_data carries no pc.
// RULE25: vector is fetched as one 32-bit word and used as the full pc.
module rtev_core
  import rtev_pkg::*;
#(
  parameter bit MANUAL_RESET_EN = 1'b1
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hard_reset_pin_n,
  input wire logic nmi_pin,
  input wire logic [EXT_PINS-1:0] external_request_pins,
  input wire logic wdt_reset_req,
  input wire logic watchdog_reset_select,
  input wire logic int_req,
  input wire logic [VEC_W-1:0] int_vec,
  input wire logic [2:0] int_level,
  input wire logic insn_done,
  input wire logic insn_was_return,
  input wire logic trap_req,
  input wire logic [1:0] trap_num,
  output logic core_hold,
  output logic push_req,
  output rtev_push_s push_data,
  input wire logic push_ack,
  output logic fetch_req,
  output logic [VEC_ADDR_W-1:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic [31:0] fetch_data,
  output logic pc_load,
  output logic [31:0] pc_value,
  output logic int_taken,
  output logic cpu_init,
  output logic module_init,
  output logic busctl_port_init,
  output logic pins_to_ports,
  output logic [15:0] module_stop_control,
  output logic [1:0] intr_mode
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [EXT_PINS+1:0] pin_meta_ff;
  logic [EXT_PINS+1:0] pin_sync_ff;
  logic rst_pin_prev_ff;
  logic nmi_prev_ff;
  logic rst_low;
  logic rst_rise;
  logic nmi_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_ff <= {(EXT_PINS+2){1'b1}};
      pin_sync_ff <= {(EXT_PINS+2){1'b1}};
      rst_pin_prev_ff <= 1'b1;
      nmi_prev_ff <= 1'b1;
    end
    else
    begin
      pin_meta_ff <= {external_request_pins, nmi_pin, hard_reset_pin_n};
      pin_sync_ff <= pin_meta_ff;
      rst_pin_prev_ff <= pin_sync_ff[0];
      nmi_prev_ff <= pin_sync_ff[1];
    end
  end

  assign rst_low = !pin_sync_ff[0];
  assign rst_rise = pin_sync_ff[0] && !rst_pin_prev_ff;
  assign nmi_rise = pin_sync_ff[1] && !nmi_prev_ff;

  // ****************************************
  // state and cpu control registers
  // ****************************************
  rtev_state_e state_ff;
  rtev_exc_s exc_ff;
  logic [7:0] cond_ff;
  logic [7:0] xctl_ff;
  logic [1:0] mode_ff;
  logic [15:0] mstp_ff;
  logic manual_sel_ff;
  logic nmi_pend_ff;
  logic wr_en;
  logic rd_en;
  logic trace_go;
  logic irq_go;
  logic trap_go;
  logic [VEC_W-1:0] irq_vec;
  logic irq_any;
  logic wdt_manual;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign wdt_manual = MANUAL_RESET_EN && watchdog_reset_select; // RULE9

  // trace decision at instruction end; mask bits not consulted
  assign trace_go = (mode_ff == MODE_2) && xctl_ff[XC_TRACE_BIT] && !insn_was_return; // RULE17 RULE18 RULE19 RULE22

  // interrupt request selection: nmi, then pins, then internal
  always_comb
  begin
    irq_any = 1'b0;
    irq_vec = VEC_NMI;
    if (nmi_pend_ff)
    begin
      irq_any = 1'b1;
      irq_vec = VEC_NMI; // RULE2
    end
    else if (!cond_ff[CC_MASK_BIT] && ((mode_ff != MODE_2) || (EXT_PIN_LEVEL > xctl_ff[XC_LVL_LSB +: 3]))
             && (~pin_sync_ff[EXT_PINS+1:2] != '0))
    begin
      irq_any = 1'b1;
      for (int i = EXT_PINS-1; i >= 0; i--)
      begin
        if (!pin_sync_ff[i+2])
        begin
          irq_vec = VEC_EXT_BASE + VEC_W'(i); // RULE2
        end
      end
    end
    else if (int_req && (int_vec >= VEC_INT_FIRST) && (int_vec <= VEC_INT_LAST) // RULE3
             && ((mode_ff == MODE_2) ? (int_level > xctl_ff[XC_LVL_LSB +: 3]) : !cond_ff[CC_MASK_BIT]))
    begin
      irq_any = 1'b1;
      irq_vec = int_vec;
    end
  end

  // interrupts only taken at an instruction end in run state
  assign irq_go = (state_ff == ST_RUN) && insn_done && !trace_go && irq_any; // RULE15 RULE21 RULE23
  assign trap_go = (state_ff == ST_RUN) && insn_done && !trace_go && !irq_any && trap_req; // RULE23

  // ****************************************
  // exception sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_RESET;
      exc_ff <= '0;
      manual_sel_ff <= 1'b0;
    end
    else if (rst_low)
    begin
      state_ff <= ST_RESET; // RULE4 RULE5
      manual_sel_ff <= MANUAL_RESET_EN && !pin_sync_ff[1]; // RULE8
    end
    else if (wdt_reset_req)
    begin
      state_ff <= ST_INIT; // RULE4
      exc_ff <= '{manual: wdt_manual, vec: wdt_manual ? VEC_MANUAL : VEC_POWER_ON}; // RULE9
    end
    else
    begin
      case (state_ff)
        ST_RESET:
        begin
          if (rst_rise)
          begin
            state_ff <= ST_INIT; // RULE6
            exc_ff <= '{manual: manual_sel_ff, vec: manual_sel_ff ? VEC_MANUAL : VEC_POWER_ON}; // RULE2
          end
        end
        ST_INIT:
        begin
          state_ff <= ST_FETCH; // RULE24
        end
        ST_PUSH:
        begin
          if (push_ack)
          begin
            state_ff <= ST_FETCH; // RULE24
          end
        end
        ST_FETCH:
        begin
          if (fetch_ack)
          begin
            state_ff <= ST_RUN; // RULE14
          end
        end
        ST_RUN:
        begin
          if (insn_done && trace_go)
          begin
            state_ff <= ST_PUSH;
            exc_ff <= '{manual: 1'b0, vec: VEC_TRACE}; // RULE23
          end
          else if (irq_go)
          begin
            state_ff <= ST_PUSH;
            exc_ff <= '{manual: 1'b0, vec: irq_vec};
          end
          else if (trap_go)
          begin
            state_ff <= ST_PUSH;
            exc_ff <= '{manual: 1'b0, vec: VEC_TRAP_BASE + {5'h00, trap_num}}; // RULE2
          end
        end
        default:
        begin
          state_ff <= ST_RESET;
        end
      endcase
    end
  end

  // nmi edge latch; new edge wins over acceptance
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nmi_pend_ff <= 1'b0;
    end
    else if (state_ff == ST_RESET || state_ff == ST_INIT)
    begin
      nmi_pend_ff <= 1'b0; // RULE15
    end
    else if (nmi_rise)
    begin
      nmi_pend_ff <= 1'b1;
    end
    else if (irq_go && irq_vec == VEC_NMI)
    begin
      nmi_pend_ff <= 1'b0;
    end
  end

  // ****************************************
  // cpu mask, trace and mode bits
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cond_ff <= CC_RESET;
      xctl_ff <= XC_RESET;
      mode_ff <= MODE_0;
    end
    else if (state_ff == ST_INIT)
    begin
      cond_ff <= CC_RESET; // RULE10 RULE13
      xctl_ff <= XC_RESET; // RULE13
      mode_ff <= MODE_0; // RULE7
    end
    else if (state_ff == ST_PUSH && push_ack)
    begin
      cond_ff[CC_MASK_BIT] <= 1'b1; // RULE20 RULE24
      if (mode_ff == MODE_2)
      begin
        xctl_ff[XC_TRACE_BIT] <= 1'b0; // RULE20
      end
    end
    else if (wr_en)
    begin
      if (paddr == OFF_MODE)
      begin
        mode_ff <= pwdata[1:0];
      end
      else if (paddr == OFF_COND)
      begin
        cond_ff <= pwdata[7:0];
      end
      else if (paddr == OFF_XCTL)
      begin
        xctl_ff <= pwdata[7:0]; // RULE19
      end
    end
  end

  // ****************************************
  // module stop control
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mstp_ff <= MSTP_RESET;
    end
    else if (state_ff == ST_INIT)
    begin
      mstp_ff <= MSTP_RESET; // RULE16
    end
    else if (wr_en && paddr == OFF_MSTP)
    begin
      mstp_ff <= pwdata[15:0];
    end
  end

  // ****************************************
  // vector fetch and pc load
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_load <= 1'b0;
      pc_value <= '0;
      int_taken <= 1'b0;
    end
    else
    begin
      pc_load <= (state_ff == ST_FETCH) && fetch_ack && !rst_low;
      int_taken <= irq_go && !rst_low && !wdt_reset_req;
      if (state_ff == ST_FETCH && fetch_ack)
      begin
        pc_value <= fetch_data; // RULE14 RULE25
      end
    end
  end

  assign fetch_req = (state_ff == ST_FETCH);
  assign fetch_addr = VEC_ADDR_W'({exc_ff.vec, {VEC_ENTRY_SHIFT{1'b0}}}); // RULE1
  assign push_req = (state_ff == ST_PUSH); // RULE24
  assign push_data = '{cond: cond_ff, xctl: xctl_ff};
  assign core_hold = (state_ff == ST_RESET); // RULE5
  assign cpu_init = (state_ff == ST_INIT); // RULE10
  assign module_init = (state_ff == ST_INIT); // RULE10
  assign busctl_port_init = (state_ff == ST_INIT) && !exc_ff.manual; // RULE10
  assign pins_to_ports = (state_ff == ST_INIT) && exc_ff.manual; // RULE11
  assign module_stop_control = mstp_ff;
  assign intr_mode = mode_ff;

  // ****************************************
  // apb read side
  // ****************************************
  assign pready = 1'b1;

  always_comb
  begin
    prdata = '0;
    pslverr = 1'b0;
    if (paddr == OFF_MODE)
    begin
      prdata[1:0] = mode_ff;
    end
    else if (paddr == OFF_COND)
    begin
      prdata[7:0] = cond_ff;
    end
    else if (paddr == OFF_XCTL)
    begin
      prdata[7:0] = xctl_ff;
    end
    else if (paddr == OFF_MSTP)
    begin
      prdata[15:0] = mstp_ff;
    end
    else if (paddr == OFF_STATUS)
    begin
      prdata[VEC_W-1:0] = exc_ff.vec;
      prdata[8] = exc_ff.manual;
      prdata[9] = core_hold;
    end
    else
    begin
      pslverr = psel && penable;
    end
    if (!rd_en)
    begin
      prdata = '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_vec_addr_range: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    fetch_req |-> (fetch_addr[15:2] <= 14'(VEC_INT_LAST) && fetch_addr[1:0] == 2'h0))
    else $error("vector address out of table");
  a_no_reserved_vec: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    fetch_req |-> !(exc_ff.vec inside {7'h02, 7'h03, 7'h04, 7'h06, [7'h0C:7'h0F]}))
    else $error("reserved vector generated");
  a_reset_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    rst_low |=> core_hold && !fetch_req)
    else $error("core not held in reset");
  a_reset_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (core_hold && rst_rise && !wdt_reset_req) |=> cpu_init ##1 fetch_req)
    else $error("reset handling did not start on rise");
  a_mode_forced: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    cpu_init |=> intr_mode == MODE_0 && cond_ff[CC_MASK_BIT] && !xctl_ff[XC_TRACE_BIT])
    else $error("reset entry state wrong");
  a_mstp_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    cpu_init |=> module_stop_control == MSTP_RESET)
    else $error("module stop not loaded");
  a_reset_type: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (core_hold && rst_rise && !wdt_reset_req) |=> exc_ff.manual == $past(manual_sel_ff))
    else $error("reset type mismatch");
  a_trace_mode0: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    (state_ff == ST_RUN && insn_done && mode_ff == MODE_0 && !rst_low && !wdt_reset_req)
    |=> exc_ff.vec != VEC_TRACE || state_ff == ST_RUN)
    else $error("trace raised in mode 0");
  a_trace_entry: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    (push_req && push_ack && exc_ff.vec == VEC_TRACE && !rst_low && !wdt_reset_req)
    |=> cond_ff[CC_MASK_BIT] && !xctl_ff[XC_TRACE_BIT]
        && xctl_ff[XC_LVL_LSB +: 3] == $past(xctl_ff[XC_LVL_LSB +: 3])
        && cond_ff[CC_USER_BIT] == $past(cond_ff[CC_USER_BIT]))
    else $error("trace entry mask update wrong");
  a_push_first: assert property (@(posedge pclk) disable iff (!presetn) // RULE24
    (state_ff == ST_RUN && (trace_go || irq_go || trap_go) && insn_done && !rst_low && !wdt_reset_req)
    |=> push_req && !fetch_req)
    else $error("vectoring without push");
  a_pc_from_vec: assert property (@(posedge pclk) disable iff (!presetn) // RULE25
    (fetch_req && fetch_ack && !rst_low && !wdt_reset_req) |=> pc_load && pc_value == $past(fetch_data))
    else $error("pc not loaded from vector");
  c_manual_reset: cover property (@(posedge pclk) disable iff (!presetn) pins_to_ports);
  c_trace_taken: cover property (@(posedge pclk) disable iff (!presetn) push_req && exc_ff.vec == VEC_TRACE);
  c_nmi_taken: cover property (@(posedge pclk) disable iff (!presetn) int_taken && exc_ff.vec == VEC_NMI);
  c_trap_taken: cover property (@(posedge pclk) disable iff (!presetn) push_req && exc_ff.vec == VEC_TRAP_BASE);
endmodule : rtev_core
`default_nettype wire

//--- src/rtev_pkg.sv
`default_nettype none
package rtev_pkg;
  // ****************************************
  // vector numbers and addressing
  // ****************************************
  localparam int VEC_W = 7;
  localparam logic [VEC_W-1:0] VEC_POWER_ON = 7'h00;
  localparam logic [VEC_W-1:0] VEC_MANUAL = 7'h01;
  localparam logic [VEC_W-1:0] VEC_TRACE = 7'h05;
  localparam logic [VEC_W-1:0] VEC_NMI = 7'h07;
  localparam logic [VEC_W-1:0] VEC_TRAP_BASE = 7'h08;
  localparam logic [VEC_W-1:0] VEC_EXT_BASE = 7'h10;
  localparam logic [VEC_W-1:0] VEC_INT_FIRST = 7'h18;
  localparam logic [VEC_W-1:0] VEC_INT_LAST = 7'h5B;
  localparam int VEC_ADDR_W = 16;
  localparam int VEC_ENTRY_SHIFT = 2;
  localparam int EXT_PINS = 8;

  // ****************************************
  // cpu control bits
  // ****************************************
  localparam int CC_MASK_BIT = 7;
  localparam int CC_USER_BIT = 6;
  localparam int XC_TRACE_BIT = 7;
  localparam int XC_LVL_LSB = 0;
  localparam logic [7:0] CC_RESET = 8'h80;
  localparam logic [7:0] XC_RESET = 8'h07;
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [15:0] MSTP_RESET = 16'h3FFF;
  localparam logic [2:0] EXT_PIN_LEVEL = 3'h7;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_COND = 8'h04;
  localparam logic [7:0] OFF_XCTL = 8'h08;
  localparam logic [7:0] OFF_MSTP = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  typedef enum {ST_RESET, ST_INIT, ST_PUSH, ST_FETCH, ST_RUN} rtev_state_e;

  typedef struct packed {
    logic [7:0] cond;
    logic [7:0] xctl;
  } rtev_push_s;

  typedef struct packed {
    logic manual;
    logic [VEC_W-1:0] vec;
  } rtev_exc_s;
endpackage : rtev_pkg
`default_nettype wire

//--- verification/rtev_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtev_cpu_model
  import rtev_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic push_req,
  output logic push_ack,
  input wire logic fetch_req,
  input wire logic [VEC_ADDR_W-1:0] fetch_addr,
  output logic fetch_ack,
  output logic [31:0] fetch_data
);
  logic [1:0] wait_ff;
  // ****
  // stack push and vector fetch answers
  // ****
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      push_ack <= 1'b0;
      fetch_ack <= 1'b0;
      fetch_data <= 32'h0;
      wait_ff <= 2'h0;
    end
    else
    begin
      push_ack <= 1'b0;
      fetch_ack <= 1'b0;
      // idle data toggles each cycle, so a stale word comes back every other cycle
      fetch_data <= ~fetch_data;
      if ((push_req && !push_ack) || (fetch_req && !fetch_ack))
      begin
        if (wait_ff == (slow ? 2'h3 : 2'h0))
        begin
          wait_ff <= 2'h0;
          push_ack <= push_req;
          fetch_ack <= fetch_req && !push_req;
          if (fetch_req && !push_req)
            fetch_data <= {16'h5A00, fetch_addr};
        end
        else
          wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule : rtev_cpu_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rtev_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hard_reset_pin_n = 1'b1, nmi_pin = 1'b1, wdt_reset_req = 1'b0, watchdog_reset_select = 1'b0;
  logic int_req = 1'b0, insn_done = 1'b0, insn_was_return = 1'b0, trap_req = 1'b0;
  logic [EXT_PINS-1:0] external_request_pins = 8'hFF;
  logic [VEC_W-1:0] int_vec = 7'h18;
  logic [2:0] int_level = 3'h0;
  logic [1:0] trap_num = 2'h0;
  logic [31:0] prdata, pc_value, fetch_data, rd;
  logic pready, pslverr, core_hold, push_req, push_ack, fetch_req, fetch_ack, pc_load, int_taken, err;
  logic cpu_init, module_init, busctl_port_init, pins_to_ports;
  rtev_push_s push_data, pushed_val;
  logic int_seen = 1'b0;
  logic [15:0] fetch_addr, module_stop_control;
  logic [1:0] intr_mode;
  int failures = 0, check_count = 0;

  rtev_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hard_reset_pin_n(hard_reset_pin_n), .nmi_pin(nmi_pin), .external_request_pins(external_request_pins),
    .wdt_reset_req(wdt_reset_req), .watchdog_reset_select(watchdog_reset_select), .int_req(int_req),
    .int_vec(int_vec), .int_level(int_level), .insn_done(insn_done), .insn_was_return(insn_was_return),
    .trap_req(trap_req), .trap_num(trap_num), .core_hold(core_hold), .push_req(push_req),
    .push_data(push_data), .push_ack(push_ack), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .pc_load(pc_load), .pc_value(pc_value),
    .int_taken(int_taken), .cpu_init(cpu_init), .module_init(module_init),
    .busctl_port_init(busctl_port_init), .pins_to_ports(pins_to_ports),
    .module_stop_control(module_stop_control), .intr_mode(intr_mode));

  rtev_cpu_model cpu (.pclk(pclk), .presetn(presetn), .slow(slow), .push_req(push_req), .push_ack(push_ack),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data));

  initial
  begin
    forever #2 pclk = ~pclk;
  end

  // ****
  // shared tasks
  // ****
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task timeout;
    failures++;
    $display("mismatch wait expected done seen hang");
    wrap_up();
  endtask : timeout

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      timeout();
    @(posedge pclk);
  endtask : apb

  task pulse_insn(input logic ret, input logic trap);
    insn_done <= 1'b1;
    insn_was_return <= ret;
    trap_req <= trap;
    @(posedge pclk);
    insn_done <= 1'b0;
    insn_was_return <= 1'b0;
    trap_req <= 1'b0;
  endtask : pulse_insn

  task exc(input logic [15:0] a, input logic pushed);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    int_seen = 1'b0;
    do
    begin
      @(posedge pclk);
      seen |= (push_req === 1'b1);
      if (push_req === 1'b1)
        pushed_val = push_data;
      int_seen |= (int_taken === 1'b1);
      n++;
    end while (fetch_req !== 1'b1 && n < 100);
    if (n >= 100)
      timeout();
    chk("fetch_addr", {16'h0, a}, {16'h0, fetch_addr});
    chk("push_seen", {31'h0, pushed}, {31'h0, seen});
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pc_load !== 1'b1 && n < 100);
    if (n >= 100)
      timeout();
    chk("pc_value", {16'h5A00, a}, pc_value);
  endtask : exc

  task none_exc;
    logic seen;
    seen = 1'b0;
    repeat (10)
    begin
      @(posedge pclk);
      seen |= (push_req === 1'b1) | (fetch_req === 1'b1);
    end
    chk("no_exception", 32'h0, {31'h0, seen});
  endtask : none_exc

  task wait_init(input logic man);
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (cpu_init !== 1'b1 && n < 50);
    if (n >= 50)
      timeout();
    chk("module_init", 32'h1, {31'h0, module_init});
    chk("busctl_port_init", {31'h0, !man}, {31'h0, busctl_port_init});
    chk("pins_to_ports", {31'h0, man}, {31'h0, pins_to_ports});
  endtask : wait_init

  task do_reset(input logic nmi, input logic [15:0] a);
    hard_reset_pin_n <= 1'b0;
    nmi_pin <= nmi;
    repeat (20) @(posedge pclk);
    chk("core_hold", 32'h1, {31'h0, core_hold});
    none_exc();
    hard_reset_pin_n <= 1'b1;
    wait_init(!nmi);
    exc(a, 1'b0);
    chk("mstp", 32'h3FFF, {16'h0, module_stop_control});
    chk("mode", 32'h0, {30'h0, intr_mode});
    apb(1'b0, OFF_COND, 32'h0);
    chk("cond", 32'h80, rd);
    apb(1'b0, OFF_XCTL, 32'h0);
    chk("xctl_trace", 32'h0, {31'h0, rd[7]});
  endtask : do_reset

  // ****
  // scenarios
  // ****
  task sc_trace;
    apb(1'b1, OFF_MODE, 32'h2);
    apb(1'b1, OFF_COND, 32'h40);
    apb(1'b1, OFF_XCTL, 32'h83);
    pulse_insn(1'b0, 1'b0);
    exc(16'h0014, 1'b1);
    chk("push_data", 32'h4083, {16'h0, pushed_val});
    chk("int_taken", 32'h0, {31'h0, int_seen});
    apb(1'b0, OFF_XCTL, 32'h0);
    chk("xctl", 32'h03, rd);
    apb(1'b0, OFF_COND, 32'h0);
    chk("cond", 32'hC0, rd);
    pulse_insn(1'b0, 1'b0);
    none_exc();
    apb(1'b1, OFF_XCTL, 32'h87);
    pulse_insn(1'b1, 1'b0);
    none_exc();
    int_req <= 1'b1;
    int_vec <= 7'h5B;
    pulse_insn(1'b0, 1'b1);
    exc(16'h0014, 1'b1);
    apb(1'b1, OFF_MODE, 32'h0);
    apb(1'b1, OFF_COND, 32'h0);
    pulse_insn(1'b0, 1'b1);
    exc(16'h016C, 1'b1);
    chk("int_taken", 32'h1, {31'h0, int_seen});
    int_req <= 1'b0;
    apb(1'b1, OFF_XCTL, 32'h80);
    pulse_insn(1'b0, 1'b0);
    none_exc();
    apb(1'b0, 8'h40, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
  endtask : sc_trace

  task sc_trap_pins;
    slow <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      trap_num <= 2'(i);
      pulse_insn(1'b0, 1'b1);
      exc(16'h0020 + 16'(4 * i), 1'b1);
    end
    slow <= 1'b0;
    apb(1'b1, OFF_COND, 32'h0);
    external_request_pins <= 8'hDB;
    repeat (4) @(posedge pclk);
    pulse_insn(1'b0, 1'b0);
    exc(16'h0048, 1'b1);
    chk("int_taken", 32'h1, {31'h0, int_seen});
    external_request_pins <= 8'hFF;
  endtask : sc_trap_pins

  task sc_manual;
    apb(1'b1, OFF_MODE, 32'h2);
    apb(1'b1, OFF_MSTP, 32'h0);
    do_reset(1'b0, 16'h0004);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", 32'h101, rd);
    nmi_pin <= 1'b1;
    none_exc();
    pulse_insn(1'b0, 1'b0);
    exc(16'h001C, 1'b1);
  endtask : sc_manual

  task sc_watchdog;
    for (int s = 0; s < 2; s++)
    begin
      watchdog_reset_select <= s[0];
      wdt_reset_req <= 1'b1;
      @(posedge pclk);
      wdt_reset_req <= 1'b0;
      wait_init(s[0]);
      exc(s[0] ? 16'h0004 : 16'h0000, 1'b0);
    end
  endtask : sc_watchdog

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    do_reset(1'b1, 16'h0000);
    sc_trace();
    sc_trap_pins();
    sc_manual();
    sc_watchdog();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
